// [include/power_on_ctrl_pkg.sv]
// Constants and types for the power-on restore and remote-state control block
`default_nettype none
package power_on_ctrl_pkg;
  // Widths
  localparam int SETPT_W = 16;
  localparam int MODE_W  = 3;
  localparam int RSTATE_W = 2;
  // Remote state encodings
  localparam logic [1:0] RSTATE_PANEL  = 2'h0;
  localparam logic [1:0] RSTATE_ARMED  = 2'h1;
  localparam logic [1:0] RSTATE_REMOTE = 2'h2;
  localparam logic [1:0] RSTATE_FACTORY = RSTATE_ARMED;
  // Factory default settings
  localparam logic [15:0] VSET_DEFAULT = 16'h0000;
  localparam logic [15:0] ISET_DEFAULT = 16'h0000;
  localparam logic [2:0]  MODE_UI      = 3'h0;
  localparam logic        OUT_DEFAULT  = 1'b0;
  // Control modes shown to the rest of the unit
  typedef enum logic [1:0] {CTL_LOCAL, CTL_REMOTE, CTL_LOCKOUT} ctl_mode_t;
endpackage
`default_nettype wire

// [verilog/power_on_ctrl.sv]
// Power-on setting restore and remote/lockout control state machine
// Functional notes
// - With remember-last off, power-up applies 0 V, 0 A, UI mode and output off.
// - With remember-last on, power-up applies the settings saved before power-down.
// - The power-on selection is non-volatile and only a front panel edit changes it.
// - The last go-to-remote parameter from 0 to 2 is stored non-volatile and sets the power-up remote state; 3 is refused.
// - The stored remote state is never reported, so the host must write it when unsure.
// - State 0 powers up local; a parameterless go-to-remote enables remote control with the front panel locked out.
// - State 1 powers up local and goes to remote lockout on the first command received.
// - In state 1 a go-to-local command leaves the unit under front panel control.
// - The factory value of the stored remote state is 1.
// - State 2 powers up directly in remote control with the front panel locked out.
`default_nettype none
module power_on_ctrl
  import power_on_ctrl_pkg::*;
#(
  parameter int SW = SETPT_W
) (
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          srst,
  // Power-up pulse and non-volatile image
  input  wire logic          power_up,
  input  wire logic          nv_valid,
  input  wire logic          nv_remember,
  input  wire logic [1:0]    nv_rstate,
  input  wire logic [SW-1:0] nv_vset,
  input  wire logic [SW-1:0] nv_iset,
  input  wire logic [2:0]    nv_mode,
  input  wire logic          nv_output,
  // Front panel edit of the power-on selection
  input  wire logic          panel_edit,
  input  wire logic          panel_remember,
  // Commands from the digital interfaces
  input  wire logic          cmd_any,
  input  wire logic          go_to_remote_cmd,
  input  wire logic          remote_has_param,
  input  wire logic [1:0]    remote_param,
  input  wire logic          go_to_local_cmd,
  // Applied settings
  output logic [SW-1:0]      vset_r,
  output logic [SW-1:0]      iset_r,
  output logic [2:0]         mode_r,
  output logic               output_en_r,
  output logic               load_pulse_r,
  // Non-volatile write-back image
  output logic               remember_r,
  output logic [1:0]         rstate_r,
  output logic               nv_write_r,
  // Control mode
  output ctl_mode_t          ctl_r,
  output logic               panel_lock_r
);

  // ==========================================================
  // Power-up loading
  // ==========================================================
  // Stale image counts as invalid, so a blank store behaves as shipped
  wire logic        rem_eff    = nv_valid & nv_remember;
  wire logic [1:0]  rstate_eff = (nv_valid && nv_rstate <= RSTATE_REMOTE) ? nv_rstate
                                                                        : RSTATE_FACTORY;
  wire logic        remote_ok  = go_to_remote_cmd & remote_has_param
                                 & (remote_param <= RSTATE_REMOTE);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      vset_r       <= VSET_DEFAULT;
      iset_r       <= ISET_DEFAULT;
      mode_r       <= MODE_UI;
      output_en_r  <= OUT_DEFAULT;
      load_pulse_r <= 1'b0;
    end else begin
      load_pulse_r <= power_up;
      if (power_up) begin
        vset_r      <= rem_eff ? nv_vset   : VSET_DEFAULT;
        iset_r      <= rem_eff ? nv_iset   : ISET_DEFAULT;
        mode_r      <= rem_eff ? nv_mode   : MODE_UI;
        output_en_r <= rem_eff ? nv_output : OUT_DEFAULT;
      end
    end
  end

  // ==========================================================
  // Non-volatile selections
  // ==========================================================
  // stored fields; no read path exists
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      remember_r <= 1'b0;
      rstate_r   <= RSTATE_FACTORY;
      nv_write_r <= 1'b0;
    end else begin
      nv_write_r <= (panel_edit | remote_ok) & ~power_up;
      if (power_up) begin
        remember_r <= rem_eff;
        rstate_r   <= rstate_eff;
      end else begin
        if (panel_edit)
          remember_r <= panel_remember;
        if (remote_ok)
          rstate_r <= remote_param;
      end
    end
  end

  // ==========================================================
  // Control mode
  // ==========================================================
  // Armed means state 1 still waiting for its first command
  logic armed_r;
  wire ctl_mode_t ctl_boot = (rstate_eff == RSTATE_REMOTE) ? CTL_LOCKOUT : CTL_LOCAL;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctl_r        <= CTL_LOCAL;
      armed_r      <= 1'b0;
      panel_lock_r <= 1'b0;
    end else if (power_up) begin
      ctl_r        <= ctl_boot;
      armed_r      <= (rstate_eff == RSTATE_ARMED);
      panel_lock_r <= (rstate_eff == RSTATE_REMOTE);
    end else if (go_to_local_cmd) begin
      ctl_r        <= CTL_LOCAL;
      armed_r      <= 1'b0;
      panel_lock_r <= 1'b0;
    end else if (go_to_remote_cmd && !remote_has_param) begin
      ctl_r        <= CTL_LOCKOUT;
      armed_r      <= 1'b0;
      panel_lock_r <= 1'b1;
    end else if (armed_r && cmd_any) begin
      ctl_r        <= CTL_LOCKOUT;
      armed_r      <= 1'b0;
      panel_lock_r <= 1'b1;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  property p_defaults;
    @(posedge ref_clk) disable iff (srst)
      power_up && !rem_eff |=> vset_r == VSET_DEFAULT && iset_r == ISET_DEFAULT
                               && mode_r == MODE_UI && !output_en_r;
  endproperty
  a_defaults: assert property (p_defaults) else $error("defaults not applied");

  property p_restore;
    @(posedge ref_clk) disable iff (srst)
      power_up && rem_eff |=> vset_r == $past(nv_vset) && mode_r == $past(nv_mode)
                              && iset_r == $past(nv_iset) && output_en_r == $past(nv_output);
  endproperty
  a_restore: assert property (p_restore) else $error("settings not restored");

  property p_sel_hold;
    @(posedge ref_clk) disable iff (srst)
      !srst && !panel_edit && !power_up |=> $stable(remember_r);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("selection changed");

  property p_remote_store;
    @(posedge ref_clk) disable iff (srst)
      remote_ok && !power_up |=> rstate_r == $past(remote_param) && nv_write_r;
  endproperty
  a_remote_store: assert property (p_remote_store) else $error("remote state not stored");

  property p_bad_param;
    @(posedge ref_clk) disable iff (srst)
      !srst && go_to_remote_cmd && remote_param == 2'h3 && !power_up |=> $stable(rstate_r);
  endproperty
  a_bad_param: assert property (p_bad_param) else $error("bad parameter stored");

  sequence s_boot(logic [1:0] st);
    power_up && rstate_eff == st && !go_to_local_cmd;
  endsequence

  property p_state0;
    @(posedge ref_clk) disable iff (srst)
      s_boot(RSTATE_PANEL) |=> ctl_r == CTL_LOCAL && !armed_r;
  endproperty
  a_state0: assert property (p_state0) else $error("state 0 boot wrong");

  property p_state1;
    @(posedge ref_clk) disable iff (srst)
      s_boot(RSTATE_ARMED) ##1 (cmd_any && !go_to_local_cmd && !power_up)
        |=> ctl_r == CTL_LOCKOUT && panel_lock_r;
  endproperty
  a_state1: assert property (p_state1) else $error("first command no lockout");

  property p_go_local;
    @(posedge ref_clk) disable iff (srst)
      go_to_local_cmd && !power_up |=> ctl_r == CTL_LOCAL && !panel_lock_r;
  endproperty
  a_go_local: assert property (p_go_local) else $error("go-to-local not honoured");

  property p_state2;
    @(posedge ref_clk) disable iff (srst)
      power_up && rstate_eff == RSTATE_REMOTE |=> ctl_r == CTL_LOCKOUT && panel_lock_r;
  endproperty
  a_state2: assert property (p_state2) else $error("state 2 boot wrong");

  // Load strobe mirrors the power-up pulse one cycle later
  property p_load_pulse;
    @(posedge ref_clk) disable iff (srst)
      1'b1 |=> load_pulse_r == $past(power_up);
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("load pulse wrong");

  property p_nv_boot;
    @(posedge ref_clk) disable iff (srst)
      power_up |=> remember_r == $past(rem_eff) && rstate_r == $past(rstate_eff);
  endproperty
  a_nv_boot: assert property (p_nv_boot) else $error("stored fields not loaded");

  property p_panel_store;
    @(posedge ref_clk) disable iff (srst)
      panel_edit && !power_up |=> remember_r == $past(panel_remember) && nv_write_r;
  endproperty
  a_panel_store: assert property (p_panel_store) else $error("panel edit not stored");

  // Power-up owns the image, so no write-back may follow it
  property p_edit_boot;
    @(posedge ref_clk) disable iff (srst)
      power_up |=> !nv_write_r;
  endproperty
  a_edit_boot: assert property (p_edit_boot) else $error("write during power-up");

endmodule
`default_nettype wire

// [bench/host_model.sv]
// Remote host model issuing commands
`default_nettype none
module host_model (
  // Clock
  input  wire logic       ref_clk,
  // Command lines
  output logic            cmd_any,
  output logic            go_to_remote_cmd,
  output logic            remote_has_param,
  output logic [1:0]      remote_param,
  output logic            go_to_local_cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Idle at time zero
  initial {cmd_any, go_to_remote_cmd, remote_has_param, remote_param, go_to_local_cmd} = 6'h00;
  // explicit state writes
  // Kind 0 plain, 1 remote, 2 local; every command counts as received
  task automatic send(input logic [1:0] k, input logic hp, input logic [1:0] p);
    @(posedge ref_clk);
    {cmd_any, go_to_remote_cmd, go_to_local_cmd} <= {1'b1, k == 2'h1, k == 2'h2};
    {remote_has_param, remote_param} <= {hp, p};
    @(posedge ref_clk);
    {cmd_any, go_to_remote_cmd, go_to_local_cmd} <= 3'h0;
    // Qualifiers flip once released, so stale values never match the last command
    {remote_has_param, remote_param} <= ~{hp, p};
  endtask
endmodule
`default_nettype wire

// [bench/tb_power_on_remote_state_control.sv]
// Bench for the power-on restore and remote-state block
`default_nettype none
module tb_power_on_remote_state_control
  import power_on_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Signals
  logic        ref_clk = 1'b0;
  logic        srst, power_up, nv_valid, nv_remember, nv_output, panel_edit, panel_remember;
  logic [1:0]  nv_rstate, remote_param, rstate_r, st_exp;
  logic [1:0]  rk, rp, rs;
  logic        rh;
  logic [15:0] nv_vset, nv_iset, vset_r, iset_r;
  logic [2:0]  nv_mode, mode_r;
  logic        cmd_any, go_to_remote_cmd, remote_has_param, go_to_local_cmd, rem_exp;
  logic        output_en_r, load_pulse_r, remember_r, nv_write_r, panel_lock_r;
  ctl_mode_t   ctl_r;
  int          err_total = 0;
  int          comparisons = 0;
  wire [35:0]  img = {nv_vset, nv_iset, nv_mode, nv_output};
  wire [35:0]  live = {vset_r, iset_r, mode_r, output_en_r};
  localparam logic [35:0] DFLT = {VSET_DEFAULT, ISET_DEFAULT, MODE_UI, OUT_DEFAULT};
  always #20 ref_clk = ~ref_clk;
  power_on_ctrl dut_u (.ref_clk, .srst, .power_up, .nv_valid, .nv_remember, .nv_rstate,
    .nv_vset, .nv_iset, .nv_mode, .nv_output, .panel_edit, .panel_remember, .cmd_any,
    .go_to_remote_cmd, .remote_has_param, .remote_param, .go_to_local_cmd, .vset_r, .iset_r,
    .mode_r, .output_en_r, .load_pulse_r, .remember_r, .rstate_r, .nv_write_r, .ctl_r,
    .panel_lock_r);
  host_model host_u (.ref_clk, .cmd_any, .go_to_remote_cmd, .remote_has_param, .remote_param,
    .go_to_local_cmd);
  // ==========
  // Compare and verdict
  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test;
    if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Control state {armed, locked} after one host command; every command counts as received
  function automatic logic [1:0] ctl_step(input logic [1:0] cur, input logic [1:0] k,
                                          input logic hp);
    if (k == 2'h2) return 2'h0;
    if (k == 2'h1 && !hp) return 2'h1;
    if (cur[1]) return 2'h1;
    return cur;
  endfunction
  // Power-up with a random image; an invalid image or state 3 falls back to factory
  task automatic boot(input logic v, input logic [1:0] s);
    logic r;
    r = 1'($urandom);
    st_exp = (!v || s == 2'h3) ? RSTATE_FACTORY : s;
    rem_exp = v & r;
    @(posedge ref_clk);
    {power_up, nv_valid, nv_remember, nv_rstate} <= {1'b1, v, r, s};
    {nv_mode, nv_output, nv_vset, nv_iset} <= {4'($urandom), $urandom};
    @(posedge ref_clk);
    power_up <= 1'b0;
    #1;
    chk("load", load_pulse_r, 1'b1);
    chk("settings", live, rem_exp ? img : DFLT);
    chk("remember", remember_r, rem_exp);
    chk("rstate", rstate_r, st_exp);
    chk("boot_ctl", ctl_r, st_exp == RSTATE_REMOTE ? CTL_LOCKOUT : CTL_LOCAL);
    chk("boot_lock", panel_lock_r, st_exp == RSTATE_REMOTE);
  endtask
  task automatic cmd(input logic [1:0] k, input logic hp, input logic [1:0] p, ctl_mode_t e);
    host_u.send(k, hp, p);
    #1;
    chk("ctl", ctl_r, e);
    chk("lock", panel_lock_r, e == CTL_LOCKOUT);
  endtask
  // ==========
  // Main sequence
  initial begin
    {srst, power_up, nv_valid, nv_remember, nv_rstate, nv_output, panel_edit} = 8'h80;
    {panel_remember, nv_vset, nv_iset, nv_mode} = 36'h0;
    void'($urandom(32'hF6C0));
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    #1;
    chk("rst_rstate", rstate_r, RSTATE_FACTORY);
    // Every stored state, invalid images last
    for (int i = 0; i < 16; i++) begin
      boot(i < 12, 2'(i));
      if (st_exp == RSTATE_PANEL) begin
        cmd(2'h0, 1'b0, 2'h0, CTL_LOCAL);
        cmd(2'h1, 1'b0, 2'h0, CTL_LOCKOUT);
      end else if (st_exp == RSTATE_ARMED) begin
        if (i[2]) cmd(2'h2, 1'b0, 2'h0, CTL_LOCAL);
        cmd(2'h0, 1'b0, 2'h0, i[2] ? CTL_LOCAL : CTL_LOCKOUT);
      end else cmd(2'h0, 1'b0, 2'h0, CTL_LOCKOUT);
    end
    // Parameter 3 is refused, the others stored back to back
    boot(1'b1, RSTATE_REMOTE);
    for (int p = 3; p >= 0; p--) begin
      cmd(2'h1, 1'b1, 2'(p), CTL_LOCKOUT);
      if (p != 3) st_exp = 2'(p);
      chk("remote_store", rstate_r, st_exp);
      chk("remote_write", nv_write_r, p != 3);
    end
    // Random host traffic from a random boot state, held against the bench model
    boot(1'b1, 2'($urandom));
    rs = {st_exp == RSTATE_ARMED, st_exp == RSTATE_REMOTE};
    repeat (32) begin
      rk = 2'($urandom % 3);
      rh = 1'($urandom);
      rp = 2'($urandom);
      rs = ctl_step(rs, rk, rh);
      cmd(rk, rh, rp, rs[0] ? CTL_LOCKOUT : CTL_LOCAL);
      if (rk == 2'h1 && rh && rp != 2'h3) st_exp = rp;
      chk("rand_rstate", rstate_r, st_exp);
    end
    // First command in the very cycle after an armed power-up
    fork
      boot(1'b1, RSTATE_ARMED);
      begin
        @(posedge ref_clk);
        host_u.send(2'h0, 1'b0, 2'h0);
      end
    join
    #1;
    chk("first_cmd", {ctl_r, panel_lock_r}, {CTL_LOCKOUT, 1'b1});
    // Reset in mid-run returns every output to its shipped state
    @(posedge ref_clk);
    srst <= 1'b1;
    @(posedge ref_clk);
    srst <= 1'b0;
    #1;
    chk("rst_live", live, DFLT);
    chk("rst_nv", {remember_r, rstate_r}, {1'b0, RSTATE_FACTORY});
    chk("rst_pulse", {load_pulse_r, nv_write_r}, 2'h0);
    chk("rst_ctl", {ctl_r, panel_lock_r}, {CTL_LOCAL, 1'b0});
    // An edit that meets a power-up is dropped; the stored image wins
    @(posedge ref_clk);
    {power_up, nv_valid, nv_remember, panel_edit, panel_remember} <= 5'h1B;
    @(posedge ref_clk);
    {power_up, panel_edit} <= 2'h0;
    #1;
    chk("edit_boot", {remember_r, nv_write_r}, 2'h0);
    rem_exp = 1'b0;
    @(posedge ref_clk);
    {panel_edit, panel_remember} <= {1'b1, !rem_exp};
    @(posedge ref_clk);
    panel_edit <= 1'b0;
    #1;
    chk("edit", {remember_r, nv_write_r}, {!rem_exp, 1'b1});
    end_of_test;
  end
endmodule
`default_nettype wire
